// file: bench/pgw_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module pgw_mem_model
  import pgw_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Walker side
  input  wire pgw_mem_req_t mem_req,
  output pgw_mem_rsp_t      mem_rsp,
  // Accesses here get an error response
  input  wire logic [33:0]  bad_addr
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_q;
  wire         bad = (mem_req.addr == bad_addr);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_rsp <= '0;
      wait_q <= 2'h0;
    end else begin
      mem_rsp.valid <= 1'b0;
      // Stale data never repeats
      mem_rsp.rdata <= ~mem_rsp.rdata;
      if (mem_req.valid && !mem_rsp.valid) begin
        if (wait_q != 2'h0) begin
          wait_q <= wait_q - 2'h1;
        end else begin
          wait_q <= 2'($urandom_range(0, 3));
          mem_rsp.valid <= 1'b1;
          mem_rsp.err <= bad;
          mem_rsp.match <= 1'b0;
          if (!mem_req.write) begin
            mem_rsp.rdata <= mem[mem_req.addr[33:2]];
          end else if (!bad && mem[mem_req.addr[33:2]] == mem_req.cmp) begin
            mem_rsp.match <= 1'b1;
            mem[mem_req.addr[33:2]] = mem_req.wdata;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb_top
  import pgw_pkg::*;
;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, va, rd;
  logic [21:0]  p;
  logic [33:0]  bad_addr;
  logic [65:0]  q[$];
  logic [65:0]  n;
  logic [27:0]  tbl[12];
  pgw_mem_req_t mem_req;
  pgw_mem_rsp_t mem_rsp;
  int           error_cnt, total_checks;
  pgw_walker dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_rsp(mem_rsp));
  pgw_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_rsp(mem_rsp),
    .bad_addr(bad_addr));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] m,
                     input logic [32:0] e);
    int k;
    k = 0;
    q.push_back({m, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready && ++k < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // Reads with a zero mask are polls
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      n = q.pop_front();
      if (n[65:33] != 33'h0) `CHK({pslverr, prdata} & n[65:33], n[32:0])
    end
  end
  // Fence first so stale cached entries never mask a table change
  task automatic wk(input logic [9:0] c, input logic [4:0] st, input logic [21:0] pp);
    int k;
    apb(1, A_CMD, 32'h2, 0, 0);
    apb(1, A_CTRL, {22'h0, c}, 0, 0);
    apb(1, A_VA, va, 0, 0);
    apb(1, A_CMD, 32'h1, 0, 0);
    k = 0;
    do apb(0, A_STAT, 0, 0, 0); while (rd[0] !== 1'b0 && ++k < 100);
    if (k >= 100) begin
      error_cnt++;
      wrap_up();
    end
    apb(0, A_STAT, 0, (st == 5'h02) ? 33'h1f : 33'h1d, {28'h0, st});
    if (st == 5'h02) apb(0, A_PA, 0, 33'h3fffff, {11'h0, pp});
  endtask
  task automatic set4k(input logic [7:0] f);
    mem_u.mem[{22'h00100, va[31:22]}] = {22'h200, 2'h0, 8'h01};
    mem_u.mem[{22'h00200, va[21:12]}] = {p, 2'h0, f};
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, error_cnt, total_checks} = '0;
    presetn = 1'b0;
    bad_addr = '1;
    void'($urandom(32'h5bf12e48));
    va = $urandom;
    p = 22'($urandom);
    tbl = '{28'h101c304, 28'h102c304, 28'h102cb02, 28'h100c904, 28'h108c902, 28'h100d304,
            28'h104d302, 28'h106db04, 28'h000c304, 28'h000d302, 28'h141c308, 28'h141c702};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, A_CTRL, 0, '1, {23'h0, CTRL_RST});
    apb(0, 8'h40, 0, '1, 33'h100000000);
    apb(1, 8'h44, 32'hffff, '1, 33'h100000000);
    // Root table lives at page 0x100
    apb(1, A_ROOT, 32'h100, 0, 0);
    apb(0, A_ROOT, 0, '1, 33'h100);
    set4k(8'hc3);
    wk(10'h300, 5'h00, 0);
    $display("registers and refusal done");
    wk(10'h100, 5'h02, p);
    mem_u.mem[{22'h00100, va[31:22]}] = {p[21:10], 10'h0, 2'h0, 8'hc3};
    wk(10'h100, 5'h02, {p[21:10], va[21:12]});
    mem_u.mem[{22'h00100, va[31:22]}] = {p[21:10], 10'h1, 2'h0, 8'hc3};
    wk(10'h100, 5'h04, 0);
    foreach (tbl[i]) begin
      set4k(tbl[i][15:8]);
      wk(tbl[i][25:16], tbl[i][4:0], p);
    end
    for (int i = 0; i < 3; i++) begin
      set4k(i == 0 ? 8'hc0 : i == 1 ? 8'hc5 : 8'hc1);
      wk(10'h100, 5'h04, 0);
    end
    bad_addr = {22'h00100, va[31:22], 2'h0};
    wk(10'h100, 5'h08, 0);
    bad_addr = '1;
    $display("checks and faults done");
    set4k(8'h03);
    wk(10'h100, 5'h02, p);
    `CHK(mem_u.mem[{22'h00200, va[21:12]}], {p, 10'h043})
    set4k(8'h47);
    wk(10'h101, 5'h02, p);
    `CHK(mem_u.mem[{22'h00200, va[21:12]}], {p, 10'h0c7})
    set4k(8'h07);
    wk(10'h111, 5'h04, 0);
    `CHK(mem_u.mem[{22'h00200, va[21:12]}], {p, 10'h007})
    wk(10'h121, 5'h10, 0);
    `CHK(mem_u.mem[{22'h00200, va[21:12]}], {p, 10'h007})
    $display("flag updates done");
    wrap_up();
  end
endmodule
`default_nettype wire

// file: rtl/pgw_pkg.sv
// Summary of operation
// - Flag update ordered before triggering access
// - Access waits until flag update visible
// - Flags are only set, never cleared
// - Leaf at either level; megapage aligned
// - Reservation set within one 4 KiB page
// - Walk only when translation active; root start
// - Entry address from index; read error faults
// - Invalid or reserved entry gives page fault
// - Pointer entry descends; below zero faults
// - Misaligned superpage gives page fault
// - User flag checked against privilege settings
// - Shadow stack violation gives access fault
// - Missing permission gives page fault
// - Fault-on-flags option faults instead of updating
// - Atomic compare-and-set update, restart on mismatch
// - Physical address formed from entry and offset
// - All table accesses use full entry width
// - Private read-only incoherent translation cache
// - Cache hit needs tag match plus space-tag match or global
// - Flag updates go to memory directly
// - Speculative walks: no dirty, no fault, fenced
// - Two 10-bit indices, 12-bit offset
// - Supervisor user access gated; never execute
package pgw_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD  = 8'h04;
  localparam logic [7:0] A_ROOT = 8'h08;
  localparam logic [7:0] A_ADDRESS_SPACE_TAG = 8'h0c;
  localparam logic [7:0] A_VA   = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [7:0] A_PA   = 8'h18;
  localparam int C_STORE = 0;
  localparam int C_EXEC  = 1;
  localparam int C_SUM   = 2;
  localparam int C_MXR   = 3;
  localparam int C_FOF   = 4;
  localparam int C_SPEC  = 5;
  localparam int C_SS    = 6;
  localparam int C_PRIV  = 8;
  localparam logic [9:0] CTRL_RST = 10'h300;
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;
  localparam int K_START = 0;
  localparam int K_FENCE = 1;
  localparam int S_BUSY = 0;
  localparam int S_DONE = 1;
  localparam int S_PF   = 2;
  localparam int S_AF   = 3;
  localparam int S_DROP = 4;
  localparam int P_V = 0;
  localparam int P_R = 1;
  localparam int P_W = 2;
  localparam int P_X = 3;
  localparam int P_U = 4;
  localparam int P_G = 5;
  localparam int P_A = 6;
  localparam int P_D = 7;
  localparam logic [1:0] LVL_TOP = 2'h1;
  localparam int CE_N = 4;
  typedef enum logic [2:0] {PGW_IDLE, PGW_RD, PGW_WRD, PGW_CHK, PGW_WUPD} pgw_st_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [33:0] addr;
    logic [31:0] wdata;
    logic [31:0] cmp;
  } pgw_mem_req_t;
  typedef struct packed {
    logic        valid;
    logic        err;
    logic        match;
    logic [31:0] rdata;
  } pgw_mem_rsp_t;
  typedef struct packed {
    logic        v;
    logic [8:0]  address_space_tag;
    logic        g;
    logic [33:0] tag;
    logic [31:0] pte;
  } pgw_ce_t;
endpackage

// file: rtl/pgw_walker.sv
`timescale 1ns/1ps
`default_nettype none
module pgw_walker
  import pgw_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Table memory port
  output pgw_mem_req_t      mem_req,
  input  wire pgw_mem_rsp_t mem_rsp
);

  typedef struct packed {
    pgw_st_t              st;
    logic [1:0]           lvl;
    logic [31:0]          va;
    logic [33:0]          pa_e;
    logic [31:0]          pte;
    logic [9:0]           ctrl;
    logic [9:0]           cs;
    logic [21:0]          root;
    logic [8:0]           address_space_tag;
    logic [8:0]           address_space_tag_s;
    logic [31:0]          vreg;
    logic [4:0]           stat;
    logic [21:0]          ppn;
    logic                 nocache;
    logic                 fenced;
    logic [1:0]           rr;
    pgw_ce_t [CE_N-1:0]   ce;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
    pgw_mem_req_t         req;
  } pgw_state_t;

  pgw_state_t  q;
  pgw_state_t  d;
  logic        hit;
  logic [31:0] hpte;
  logic        f_pf;
  logic        f_af;
  logic        f_ok;
  logic [31:0] p;
  logic        st_k;

  function automatic logic [9:0] vpn(input logic [31:0] va, input logic [1:0] lvl);
    vpn = (lvl == LVL_TOP) ? va[31:22] : va[21:12];
  endfunction

  function automatic logic [33:0] ptaddr(input logic [21:0] ppn, input logic [9:0] idx);
    ptaddr = {ppn, idx, 2'h0};
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == A_CTRL) || (a == A_CMD) || (a == A_ROOT) || (a == A_ADDRESS_SPACE_TAG) ||
             (a == A_VA) || (a == A_STAT) || (a == A_PA);
  endfunction

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign mem_req = q.req;

  always_comb begin
    d    = q;
    hit  = 1'b0;
    hpte = 32'h0;
    f_pf = 1'b0;
    f_af = 1'b0;
    f_ok = 1'b0;
    p    = q.pte;
    st_k = q.cs[C_STORE] && !q.cs[C_EXEC];
    // Last matching entry wins; duplicates are harmless
    for (int k = 0; k < CE_N; k++) begin
      if (q.ce[k].v && q.ce[k].tag == q.pa_e && (q.ce[k].address_space_tag == q.address_space_tag_s || q.ce[k].g)) begin
        hit  = 1'b1;
        hpte = q.ce[k].pte;
      end
    end

    case (q.st)
      PGW_IDLE: begin
      end
      PGW_RD: begin
        // After a failed compare the cached copy is stale, so go to memory
        if (hit && !q.nocache) begin
          d.pte = hpte;
          d.st  = PGW_CHK;
        end else begin
          d.req.valid = 1'b1;
          d.req.write = 1'b0;
          d.req.addr  = q.pa_e;
          d.st        = PGW_WRD;
        end
      end
      PGW_WRD: begin
        if (mem_rsp.valid) begin
          d.req.valid = 1'b0;
          if (mem_rsp.err) begin
            f_af = 1'b1;
          end else begin
            d.pte = mem_rsp.rdata;
            d.st  = PGW_CHK;
            if (!q.fenced) begin
              d.ce[q.rr] = '{v: 1'b1, address_space_tag: q.address_space_tag_s, g: mem_rsp.rdata[P_G], tag: q.pa_e, pte: mem_rsp.rdata};
              d.rr       = q.rr + 2'h1;
            end
          end
        end
      end
      PGW_CHK: begin
        if (!p[P_V] || (!p[P_R] && p[P_W])) begin
          f_pf = 1'b1;
        end else if (!p[P_R] && !p[P_X]) begin
          // Pointer entry: D/A/U are reserved here
          if (p[P_D] || p[P_A] || p[P_U]) begin
            f_pf = 1'b1;
          end else if (q.lvl == 2'h0) begin
            f_pf = 1'b1;
          end else begin
            d.lvl     = q.lvl - 2'h1;
            d.pa_e    = ptaddr(p[31:10], vpn(q.va, q.lvl - 2'h1));
            d.nocache = 1'b0;
            d.st      = PGW_RD;
          end
        end else if (q.lvl != 2'h0 && p[19:10] != 10'h0) begin
          f_pf = 1'b1;
        end else if ((q.cs[C_PRIV +: 2] == PRIV_U && !p[P_U]) ||
                     (q.cs[C_PRIV +: 2] == PRIV_S && p[P_U] && (!q.cs[C_SUM] || q.cs[C_EXEC]))) begin
          f_pf = 1'b1;
        end else if (q.cs[C_SS] && (!p[P_W] || p[P_X])) begin
          f_af = 1'b1;
        end else if (q.cs[C_EXEC] ? !p[P_X] :
                     st_k ? !p[P_W] : !(p[P_R] || (q.cs[C_MXR] && p[P_X]))) begin
          f_pf = 1'b1;
        end else if (!p[P_A] || (st_k && !p[P_D])) begin
          if (q.cs[C_FOF]) begin
            f_pf = 1'b1;
          end else if (q.cs[C_SPEC]) begin
            f_pf = 1'b1;
          end else begin
            // Only ones are OR'd in, so no flag can drop
            d.req.valid = 1'b1;
            d.req.write = 1'b1;
            d.req.addr  = q.pa_e;
            d.req.cmp   = p;
            d.req.wdata = p | (32'h1 << P_A) | ({31'h0, st_k} << P_D);
            d.st        = PGW_WUPD;
          end
        end else begin
          f_ok = 1'b1;
        end
      end
      PGW_WUPD: begin
        // Success is reported only once memory has accepted the update
        if (mem_rsp.valid) begin
          d.req.valid = 1'b0;
          if (mem_rsp.err) begin
            f_af = 1'b1;
          end else if (mem_rsp.match) begin
            d.pte = q.req.wdata;
            f_ok  = 1'b1;
          end else begin
            d.nocache = 1'b1;
            d.st      = PGW_RD;
          end
        end
      end
      default: begin
        d.st = PGW_IDLE;
      end
    endcase

    if (f_pf || f_af || f_ok) begin
      d.st           = PGW_IDLE;
      d.stat[S_BUSY] = 1'b0;
      d.stat[S_DONE] = 1'b1;
      if (q.cs[C_SPEC] && !f_ok) begin
        d.stat[S_DROP] = 1'b1;
      end else begin
        d.stat[S_PF] = f_pf;
        d.stat[S_AF] = f_af;
      end
      if (f_ok) begin
        // Page-granular result keeps any reservation inside one base page
        d.ppn = (q.lvl == LVL_TOP) ? {d.pte[31:20], q.va[21:12]} : d.pte[31:10];
      end
    end

    d.pready = 1'b0;
    if (psel && penable && !q.pready) begin
      d.pready  = 1'b1;
      d.pslverr = !mapped(paddr);
      case (paddr)
        A_CTRL:  d.prdata = {22'h0, q.ctrl};
        A_ROOT:  d.prdata = {10'h0, q.root};
        A_ADDRESS_SPACE_TAG:  d.prdata = {23'h0, q.address_space_tag};
        A_VA:    d.prdata = q.vreg;
        A_STAT:  d.prdata = {27'h0, q.stat};
        A_PA:    d.prdata = {10'h0, q.ppn};
        default: d.prdata = 32'h0;
      endcase
    end
    if (psel && penable && q.pready && pwrite) begin
      case (paddr)
        A_CTRL: d.ctrl = pwdata[9:0];
        A_ROOT: d.root = pwdata[21:0];
        A_ADDRESS_SPACE_TAG: d.address_space_tag = pwdata[8:0];
        A_VA:   d.vreg = pwdata;
        A_CMD: begin
          // Start is dropped while busy or while machine mode owns the hart
          if (pwdata[K_START] && q.st == PGW_IDLE && q.ctrl[C_PRIV +: 2] != PRIV_M) begin
            d.st      = PGW_RD;
            d.lvl     = LVL_TOP;
            d.va      = q.vreg;
            d.cs      = q.ctrl;
            d.address_space_tag_s  = q.address_space_tag;
            d.pa_e    = ptaddr(q.root, vpn(q.vreg, LVL_TOP));
            d.stat    = 5'h1;
            d.nocache = 1'b0;
            d.fenced  = 1'b0;
          end
          if (pwdata[K_FENCE]) begin
            for (int k = 0; k < CE_N; k++) begin
              d.ce[k].v = 1'b0;
            end
            d.fenced = (d.st != PGW_IDLE);
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q      <= '0;
      q.st   <= PGW_IDLE;
      q.ctrl <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_one_outstanding: assert property (q.req.valid && !mem_rsp.valid |=> $stable(q.req))
    else $error("table request changed while outstanding");
  a_flags_only_set: assert property (q.req.valid && q.req.write |-> (q.req.wdata & q.req.cmp) == q.req.cmp)
    else $error("flag update clears a bit");
  a_done_after_update: assert property (q.st == PGW_WUPD && !mem_rsp.valid |=> !q.stat[S_DONE])
    else $error("walk done before update accepted");
  a_spec_no_write: assert property (q.cs[C_SPEC] && q.st != PGW_IDLE |-> !(q.req.valid && q.req.write))
    else $error("speculative walk updates an entry");
  a_spec_no_fault: assert property (q.cs[C_SPEC] |-> !q.stat[S_PF] && !q.stat[S_AF])
    else $error("speculative walk raised a fault");
  a_read_addr: assert property (q.req.valid && !q.req.write |->
                                q.req.addr[11:0] == {vpn(q.va, q.lvl), 2'h0})
    else $error("entry address index wrong");
  a_mega_ppn: assert property ($rose(q.stat[S_DONE]) && q.stat[4:2] == 3'h0 && q.lvl == LVL_TOP |->
                               q.ppn[9:0] == q.va[21:12])
    else $error("megapage low page number not from address");
  a_misalign_pf: assert property (q.st == PGW_CHK && q.lvl == LVL_TOP && q.pte[P_V] && q.pte[P_R] &&
                                  q.pte[19:10] != 10'h0 |=> q.stat[S_PF] || q.stat[S_DROP])
    else $error("misaligned megapage not faulted");
  a_apb_answer: assert property (psel && penable && !q.pready |=> q.pready ##1 !q.pready)
    else $error("apb answer timing wrong");

  c_walk_ok: cover property ($rose(q.stat[S_DONE]) && q.stat[4:2] == 3'h0);
  c_page_fault: cover property ($rose(q.stat[S_PF]));
  c_flag_update: cover property (q.req.valid && q.req.write && mem_rsp.valid && mem_rsp.match);
  c_restart: cover property (q.st == PGW_WUPD && mem_rsp.valid && !mem_rsp.err && !mem_rsp.match);

endmodule
`default_nettype wire
